/* logic/iofi_pkg.sv */
package iofi_pkg;
   // Fault classes, value equals the short flash count
   typedef enum logic [2:0] {
      IOFI_CLS_NONE = 3'h0,
      IOFI_CLS_OVERCURRENT = 3'h1,
      IOFI_CLS_PULSE_READBACK = 3'h2,
      IOFI_CLS_DIG_MISMATCH = 3'h3,
      IOFI_CLS_ANA_OVERCURRENT = 3'h4,
      IOFI_CLS_ANA_MISMATCH = 3'h5
   } iofi_class_t;

   typedef enum logic [2:0] {
      IOFI_ST_IDLE = 3'h0,
      IOFI_ST_SHORT_ON = 3'h1,
      IOFI_ST_SHORT_OFF = 3'h2,
      IOFI_ST_PAUSE = 3'h3,
      IOFI_ST_LONG_ON = 3'h4,
      IOFI_ST_LONG_OFF = 3'h5,
      IOFI_ST_GAP = 3'h6
   } iofi_state_t;

   localparam int IOFI_CLK_HZ = 20000000;
   // Durations in milliseconds
   localparam int IOFI_SHORT_MS = 200;
   localparam int IOFI_LONG_MS = 800;
   localparam int IOFI_PAUSE_MS = 1000;
   localparam int IOFI_LATCH_MS = 1000;
   localparam int IOFI_SHORT_CYC = IOFI_CLK_HZ / 1000 * IOFI_SHORT_MS;
   localparam int IOFI_LONG_CYC = IOFI_CLK_HZ / 1000 * IOFI_LONG_MS;
   localparam int IOFI_PAUSE_CYC = IOFI_CLK_HZ / 1000 * IOFI_PAUSE_MS;
   localparam int IOFI_LATCH_CYC = IOFI_CLK_HZ / 1000 * IOFI_LATCH_MS;
   localparam int IOFI_USER_PERIOD_CYC = IOFI_CLK_HZ / 2;
   localparam int IOFI_CNT_W = 32;
   localparam int IOFI_CH_W = 4;
endpackage

/* logic/iofi_latch.sv */
`timescale 1ns/100ps
// Holds one fault class and channel until its own timer expires
module iofi_latch
   import iofi_pkg::*;
#(
   parameter int LATCH_CYC = IOFI_LATCH_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // New fault
   input wire logic set,
   input wire iofi_class_t set_class,
   input wire logic [IOFI_CH_W-1:0] set_chan,
   // Latched fault
   output logic active_q,
   output iofi_class_t class_q,
   output logic [IOFI_CH_W-1:0] chan_q
);
   logic [IOFI_CNT_W-1:0] timer_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         active_q <= 1'b0;
         class_q <= IOFI_CLS_NONE;
         chan_q <= '0;
         timer_q <= '0;
      end else if (set) begin
         active_q <= 1'b1;
         class_q <= set_class;
         chan_q <= set_chan;
         timer_q <= IOFI_CNT_W'(LATCH_CYC - 1);
      end else if (active_q) begin
         if (timer_q == '0) begin
            active_q <= 1'b0;
         end else begin
            timer_q <= timer_q - 1'b1;
         end
      end
   end
endmodule

/* logic/iofi_top.sv */
`timescale 1ns/100ps
module iofi_top
   import iofi_pkg::*;
#(
   parameter int SHORT_CYC = IOFI_SHORT_CYC,
   parameter int LONG_CYC = IOFI_LONG_CYC,
   parameter int PAUSE_CYC = IOFI_PAUSE_CYC,
   parameter int LATCH_CYC = IOFI_LATCH_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Digital fault report
   input wire logic dig_fault,
   input wire iofi_class_t dig_class,
   input wire logic [IOFI_CH_W-1:0] dig_chan,
   // Analog fault report
   input wire logic ana_fault,
   input wire iofi_class_t ana_class,
   input wire logic [IOFI_CH_W-1:0] ana_chan,
   // User indicator configuration and value
   input wire logic user_enable,
   input wire logic [IOFI_CNT_W-1:0] user_period,
   input wire logic user_value,
   // Lamps
   output logic fault_lamp_q,
   output logic user_indicator_q
);
   logic dig_act, ana_act;
   iofi_class_t dig_cls, ana_cls;
   logic [IOFI_CH_W-1:0] dig_ch, ana_ch;
   iofi_state_t state_q;
   logic [IOFI_CNT_W-1:0] tmr_q;
   logic [2:0] shorts_q;
   logic [IOFI_CH_W:0] longs_q;
   iofi_class_t cur_cls_q;
   logic [IOFI_CH_W-1:0] cur_ch_q;
   logic show_ana_q;
   logic tmr_done;
   logic pick_dig;
   logic [IOFI_CNT_W-1:0] user_cnt_q;
   logic user_phase_q;

   // Unknown class codes and none are ignored and never set a latch
   function automatic logic valid_class(input iofi_class_t c);
      return (c >= IOFI_CLS_OVERCURRENT) && (c <= IOFI_CLS_ANA_MISMATCH);
   endfunction

   iofi_latch #(.LATCH_CYC(LATCH_CYC)) u_dig (
      .clk(clk),
      .nrst(nrst),
      .set(dig_fault && valid_class(dig_class)),
      .set_class(dig_class),
      .set_chan(dig_chan),
      .active_q(dig_act),
      .class_q(dig_cls),
      .chan_q(dig_ch)
   );

   iofi_latch #(.LATCH_CYC(LATCH_CYC)) u_ana (
      .clk(clk),
      .nrst(nrst),
      .set(ana_fault && valid_class(ana_class)),
      .set_class(ana_class),
      .set_chan(ana_chan),
      .active_q(ana_act),
      .class_q(ana_cls),
      .chan_q(ana_ch)
   );

   assign tmr_done = (tmr_q == '0);

   // Digital code next unless analog is due
   assign pick_dig = dig_act && (!ana_act || show_ana_q);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= IOFI_ST_IDLE;
         tmr_q <= '0;
         shorts_q <= '0;
         longs_q <= '0;
         cur_cls_q <= IOFI_CLS_NONE;
         cur_ch_q <= '0;
         show_ana_q <= 1'b0;
      end else if (!dig_act && !ana_act) begin
         state_q <= IOFI_ST_IDLE;
         tmr_q <= '0;
      end else begin
         case (state_q)
            IOFI_ST_IDLE, IOFI_ST_GAP: begin
               if (state_q == IOFI_ST_IDLE || tmr_done) begin
                  // Restart; alternate when both kinds latched
                  if (pick_dig) begin
                     cur_cls_q <= dig_cls;
                     cur_ch_q <= dig_ch;
                     show_ana_q <= 1'b0;
                  end else begin
                     cur_cls_q <= ana_cls;
                     cur_ch_q <= ana_ch;
                     show_ana_q <= 1'b1;
                  end
                  shorts_q <= pick_dig ? dig_cls : ana_cls;
                  longs_q <= pick_dig
                     ? {1'b0, dig_ch} + 1'b1 : {1'b0, ana_ch} + 1'b1;
                  tmr_q <= IOFI_CNT_W'(SHORT_CYC - 1);
                  state_q <= IOFI_ST_SHORT_ON;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            IOFI_ST_SHORT_ON: begin
               if (tmr_done) begin
                  shorts_q <= shorts_q - 1'b1;
                  if (shorts_q == 3'h1) begin
                     tmr_q <= IOFI_CNT_W'(PAUSE_CYC - 1);
                     state_q <= IOFI_ST_PAUSE;
                  end else begin
                     tmr_q <= IOFI_CNT_W'(SHORT_CYC - 1);
                     state_q <= IOFI_ST_SHORT_OFF;
                  end
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            IOFI_ST_SHORT_OFF: begin
               if (tmr_done) begin
                  tmr_q <= IOFI_CNT_W'(SHORT_CYC - 1);
                  state_q <= IOFI_ST_SHORT_ON;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            IOFI_ST_PAUSE: begin
               if (tmr_done) begin
                  tmr_q <= IOFI_CNT_W'(LONG_CYC - 1);
                  state_q <= IOFI_ST_LONG_ON;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            IOFI_ST_LONG_ON: begin
               if (tmr_done) begin
                  longs_q <= longs_q - 1'b1;
                  if (longs_q == (IOFI_CH_W+1)'(1)) begin
                     tmr_q <= IOFI_CNT_W'(PAUSE_CYC - 1);
                     state_q <= IOFI_ST_GAP;
                  end else begin
                     tmr_q <= IOFI_CNT_W'(LONG_CYC - 1);
                     state_q <= IOFI_ST_LONG_OFF;
                  end
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            IOFI_ST_LONG_OFF: begin
               if (tmr_done) begin
                  tmr_q <= IOFI_CNT_W'(LONG_CYC - 1);
                  state_q <= IOFI_ST_LONG_ON;
               end else begin
                  tmr_q <= tmr_q - 1'b1;
               end
            end
            default: begin
               state_q <= IOFI_ST_IDLE;
               tmr_q <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         fault_lamp_q <= 1'b0;
      end else begin
         fault_lamp_q <= (dig_act || ana_act)
            && (state_q == IOFI_ST_SHORT_ON || state_q == IOFI_ST_LONG_ON);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || !user_enable) begin
         user_cnt_q <= '0;
         user_phase_q <= 1'b1;
      end else if (user_period == '0) begin
         user_phase_q <= 1'b1;
      end else if (user_cnt_q + 1'b1 >= (user_period >> 1)) begin
         user_cnt_q <= '0;
         user_phase_q <= ~user_phase_q;
      end else begin
         user_cnt_q <= user_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         user_indicator_q <= 1'b0;
      end else begin
         user_indicator_q <= user_enable && user_value && user_phase_q;
      end
   end
endmodule

/* verif/iofi_chk.sv */
`timescale 1ns/100ps
module iofi_chk
   import iofi_pkg::*;
#(
   parameter int SHORT_CYC = 4,
   parameter int LONG_CYC = 8,
   parameter int LATCH_CYC = 200
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Fault reports
   input wire logic dig_fault,
   input wire iofi_class_t dig_class,
   input wire logic ana_fault,
   // User indicator
   input wire logic user_enable,
   input wire logic [IOFI_CNT_W-1:0] user_period,
   input wire logic user_value,
   // Lamps
   input wire logic fault_lamp_q,
   input wire logic user_indicator_q
);
   int dq;
   int aq;
   int on_len;
   int off_len;
   logic calm;
   logic far;
   always_ff @(posedge clk) begin
      if (!nrst) dq <= LATCH_CYC + 9;
      else if (dig_fault) dq <= 0;
      else if (dq < LATCH_CYC + 9) dq <= dq + 1;
   end
   always_ff @(posedge clk) begin
      if (!nrst) aq <= LATCH_CYC + 9;
      else if (ana_fault) aq <= 0;
      else if (aq < LATCH_CYC + 9) aq <= aq + 1;
   end
   always_ff @(posedge clk) begin
      on_len <= fault_lamp_q ? on_len + 1 : 0;
      off_len <= fault_lamp_q ? 0 : off_len + 1;
   end
   // Away from any latch expiry
   assign calm = (dq < LATCH_CYC - 3 || dq > LATCH_CYC + 4)
      && (aq < LATCH_CYC - 3 || aq > LATCH_CYC + 4);
   assign far = dq > LATCH_CYC + 4 && aq > LATCH_CYC + 4;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_reset_dark: assert property ($rose(nrst) |-> !fault_lamp_q && !user_indicator_q)
      else $error("lamp lit out of reset");
   chk_user_off: assert property (!user_enable |=> !user_indicator_q)
      else $error("user lamp lit while disabled");
   chk_user_follow: assert property (!user_value |=> !user_indicator_q)
      else $error("user lamp lit with value low");
   chk_user_steady: assert property (user_enable && user_value && user_period == 0
      |=> user_indicator_q)
      else $error("steady user lamp dark");
   chk_lamp_dark: assert property (far |-> !fault_lamp_q)
      else $error("fault lamp lit with no latched fault");
   chk_flash_width: assert property ($fell(fault_lamp_q) && calm
      |-> (on_len == SHORT_CYC || on_len == LONG_CYC))
      else $error("flash width wrong");
   chk_dark_gap: assert property ($rose(fault_lamp_q) |-> off_len >= SHORT_CYC)
      else $error("dark gap too short");
   chk_fault_start: assert property (dig_fault && dig_class != IOFI_CLS_NONE
      && dig_class <= IOFI_CLS_ANA_MISMATCH && far |-> ##[2:3] fault_lamp_q)
      else $error("fault lamp did not start");
endmodule

bind iofi_top iofi_chk #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC), .LATCH_CYC(LATCH_CYC))
   u_chk (.*);

/* verif/iofi_lamp_mon.sv */
`timescale 1ns/100ps
module iofi_lamp_mon #(
   parameter int SHORT_CYC = 4,
   parameter int LONG_CYC = 8,
   parameter int PAUSE_CYC = 10
) (
   // Clock and watched lamp
   input wire logic clk,
   input wire logic lamp,
   // Last complete code
   output logic [7:0] short_n = 8'h00,
   output logic [7:0] long_n = 8'h00,
   output logic [7:0] seq_cnt = 8'h00
);
   int on_len = 0;
   int off_len = 0;
   logic [7:0] sc = 8'h00;
   logic [7:0] lc = 8'h00;
   // Sorts flashes by width, reports code at gap
   always @(posedge clk) begin
      on_len <= lamp ? on_len + 1 : 0;
      off_len <= lamp ? 0 : off_len + 1;
      if (!lamp && on_len == SHORT_CYC) sc <= sc + 8'h01;
      if (!lamp && on_len == LONG_CYC) lc <= lc + 8'h01;
      if (!lamp && off_len == PAUSE_CYC - 2 && lc != 8'h00) begin
         short_n <= sc;
         long_n <= lc;
         seq_cnt <= seq_cnt + 8'h01;
         sc <= 8'h00;
         lc <= 8'h00;
      end else if (off_len > PAUSE_CYC + 2) begin
         sc <= 8'h00;
         lc <= 8'h00;
      end
   end
endmodule

/* verif/iofi_top_tb.sv */
`timescale 1ns/100ps
module iofi_top_tb;
   import iofi_pkg::*;
   localparam int TC = 200;
   logic clk = 1'h0, nrst = 1'h0, dig_fault = 1'h0, ana_fault = 1'h0;
   logic user_enable = 1'h0, user_value = 1'h0, fault_lamp_q, user_indicator_q;
   iofi_class_t dig_class = IOFI_CLS_NONE, ana_class = IOFI_CLS_NONE;
   logic [IOFI_CH_W-1:0] dig_chan = '0, ana_chan = '0;
   logic [IOFI_CNT_W-1:0] user_period = '0;
   logic [7:0] short_n, long_n, seq_cnt;
   int bad_count = 0, num_checks = 0;
   iofi_top #(.SHORT_CYC(4), .LONG_CYC(8), .PAUSE_CYC(10), .LATCH_CYC(TC)) u_dut (.*);
   iofi_lamp_mon u_mon (.clk(clk), .lamp(fault_lamp_q), .short_n(short_n),
      .long_n(long_n), .seq_cnt(seq_cnt));
   initial forever #25 clk = ~clk;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task wait_seq;
      logic [7:0] s;
      s = seq_cnt;
      for (int i = 0; i < 800 && seq_cnt === s; i++) cyc(1);
      if (seq_cnt === s) begin
         check(32'h0, 32'h1);
      end
   endtask
   task pulse(input logic ana, input iofi_class_t c, input logic [IOFI_CH_W-1:0] n);
      dig_class = c;
      ana_class = c;
      dig_chan = n;
      ana_chan = n;
      dig_fault = !ana;
      ana_fault = ana;
      cyc(1);
      dig_fault = 1'h0;
      ana_fault = 1'h0;
   endtask
   task run_len(input logic lvl, output int n);
      n = 0;
      for (int i = 0; i < 50 && user_indicator_q !== lvl; i++) cyc(1);
      while (n < 50 && user_indicator_q === lvl) begin
         n++;
         cyc(1);
      end
   endtask
   task test_codes;
      pulse(1'h0, IOFI_CLS_NONE, 4'h3);
      cyc(20);
      check(fault_lamp_q, 1'h0);
      for (int c = 1; c <= 5; c++) begin
         pulse(c > 3, iofi_class_t'(c), 4'(c - 1));
         wait_seq;
         check(short_n, c);
         check(long_n, c);
         cyc(TC + 20);
         check(fault_lamp_q, 1'h0);
      end
      $display("test codes done");
   endtask
   task test_indep;
      pulse(1'h1, IOFI_CLS_ANA_OVERCURRENT, 4'h1);
      cyc(1);
      for (int k = 0; k < 6; k++) begin
         pulse(1'h0, IOFI_CLS_OVERCURRENT, 4'h0);
         cyc(99);
      end
      wait_seq;
      check({short_n, long_n}, 16'h0101);
      wait_seq;
      check({short_n, long_n}, 16'h0101);
      cyc(TC + 20);
      check(fault_lamp_q, 1'h0);
      $display("test indep done");
   endtask
   task test_user;
      int hi;
      int lo;
      hi = 0;
      lo = 0;
      user_value = 1'h1;
      cyc(3);
      check(user_indicator_q, 1'h0);
      user_enable = 1'h1;
      cyc(3);
      check(user_indicator_q, 1'h1);
      user_value = 1'h0;
      cyc(3);
      check(user_indicator_q, 1'h0);
      user_value = 1'h1;
      user_period = 32'h6;
      run_len(1'h0, lo);
      run_len(1'h1, hi);
      run_len(1'h0, lo);
      check(hi, 3);
      check(lo, 3);
      user_enable = 1'h0;
      $display("test user done");
   endtask
   initial begin
      cyc(6);
      nrst = 1'h1;
      test_codes;
      test_indep;
      test_user;
      print_verdict;
   end
endmodule
